// *** hdl/fcms_cfg.svh ***
`ifndef FCMS_CFG_SVH
`define FCMS_CFG_SVH

`define FCMS_CLK_HZ 32'hee6b280
`define FCMS_CLK_KHZ 32'h3d090
`define FCMS_NUM_CH 3'h4

// Hold to start auto scan: 2 s
`define FCMS_HOLD_S 32'h2
`define FCMS_HOLD_CYC (`FCMS_HOLD_S * `FCMS_CLK_HZ)
// Auto scan dwell: 8 s
`define FCMS_DWELL_S 32'h8
`define FCMS_DWELL_CYC (`FCMS_DWELL_S * `FCMS_CLK_HZ)
// Relay settling after a press: 400 ms
`define FCMS_SETTLE_MS 32'h190
`define FCMS_SETTLE_CYC (`FCMS_SETTLE_MS * `FCMS_CLK_KHZ)
// Blink half period: 250 ms
`define FCMS_BLINK_MS 32'hfa
`define FCMS_BLINK_CYC (`FCMS_BLINK_MS * `FCMS_CLK_KHZ)
// Start-up step per indicator: 250 ms
`define FCMS_BOOT_MS 32'hfa
`define FCMS_BOOT_CYC (`FCMS_BOOT_MS * `FCMS_CLK_KHZ)
// Button debounce: 20 ms
`define FCMS_DEB_MS 32'h14
`define FCMS_DEB_CYC (`FCMS_DEB_MS * `FCMS_CLK_KHZ)

`endif

// *** hdl/fcms_pkg.sv ***
package fcms_pkg;

  typedef enum logic [1:0] {PH_BOOT, PH_RUN, PH_HALT} fcms_phase_t;

  typedef struct packed {
    logic autoscan;
    logic [1:0] sel;
  } fcms_nv_t;

  typedef struct packed {
    logic pfail;
    logic [3:0] uv;
    logic btn;
  } fcms_in_t;

  typedef struct packed {
    fcms_in_t s1;
    fcms_in_t s2;
    fcms_in_t s3;
    fcms_in_t clean;
    logic [31:0] deb_cnt;
  } fcms_inp_state_t;

  typedef struct packed {
    fcms_phase_t phase;
    logic [1:0] sel;
    logic [1:0] route;
    logic autoscan;
    logic settle_pend;
    logic hold_done;
    logic btn_prev;
    logic [1:0] boot_idx;
    logic [31:0] tmr;
    logic [31:0] hold_cnt;
    logic [31:0] dwell;
    logic [31:0] blink_cnt;
    logic blink;
    logic [3:0] led;
    logic [3:0] relay;
    logic nv_write;
    fcms_nv_t nv_data;
  } fcms_state_t;

  function automatic logic [3:0] fcms_onehot(input logic [1:0] idx);
    fcms_onehot = 4'h1 << idx;
  endfunction : fcms_onehot

  function automatic logic [1:0] fcms_next_ch(input logic [1:0] idx);
    fcms_next_ch = idx + 2'h1;
  endfunction : fcms_next_ch

endpackage : fcms_pkg

// *** hdl/fcms_inp.sv ***
`timescale 1ns/1ps
`include "fcms_cfg.svh"
module fcms_inp #(
  parameter logic [31:0] DEB_CYC = `FCMS_DEB_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire fcms_pkg::fcms_in_t raw,
  output fcms_pkg::fcms_in_t clean
);
  import fcms_pkg::*;

  fcms_inp_state_t s;
  fcms_inp_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = raw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // Levels count once the second and third stage agree
    next_s.clean.uv = (s.s2.uv & s.s3.uv) | (s.clean.uv & (s.s2.uv | s.s3.uv));
    next_s.clean.pfail = (s.s2.pfail == s.s3.pfail) ? s.s3.pfail : s.clean.pfail;
    // Contact bounce is filtered by requiring a stable new level for DEB_CYC
    if (s.s2.btn != s.s3.btn || s.s3.btn == s.clean.btn) begin
      next_s.deb_cnt = 32'h0;
    end else if (s.deb_cnt >= DEB_CYC - 32'h1) begin
      next_s.deb_cnt = 32'h0;
      next_s.clean.btn = s.s3.btn;
    end else begin
      next_s.deb_cnt = s.deb_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clean = s.clean;

endmodule : fcms_inp

// *** hdl/fcms_top.sv ***
`timescale 1ns/1ps
`include "fcms_cfg.svh"
module fcms_top #(
  parameter logic [31:0] HOLD_CYC = `FCMS_HOLD_CYC,
  parameter logic [31:0] DWELL_CYC = `FCMS_DWELL_CYC,
  parameter logic [31:0] SETTLE_CYC = `FCMS_SETTLE_CYC,
  parameter logic [31:0] BLINK_CYC = `FCMS_BLINK_CYC,
  parameter logic [31:0] BOOT_CYC = `FCMS_BOOT_CYC,
  parameter logic [31:0] DEB_CYC = `FCMS_DEB_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic BUTTON,
  input wire logic [3:0] UNDER_VOLT,
  input wire logic POWER_FAIL,
  input wire fcms_pkg::fcms_nv_t NV_RESTORE,
  input wire logic NV_RESTORE_VALID,
  output logic [3:0] LED,
  output logic [3:0] RELAY,
  output logic NV_WRITE,
  output fcms_pkg::fcms_nv_t NV_WDATA,
  output logic AUTOSCAN
);
  import fcms_pkg::*;

  fcms_in_t raw;
  fcms_in_t clean;
  fcms_state_t s;
  fcms_state_t next_s;
  logic press;
  logic release_evt;

  assign raw = '{pfail: POWER_FAIL, uv: UNDER_VOLT, btn: BUTTON};

  fcms_inp #(
    .DEB_CYC(DEB_CYC)
  ) u_inp (
    .clock(CLOCK),
    .rst_n(RST_N),
    .raw(raw),
    .clean(clean)
  );

  assign press = clean.btn & ~s.btn_prev;
  assign release_evt = ~clean.btn & s.btn_prev;

  always_comb begin
    next_s = s;
    next_s.nv_write = 1'b0;
    next_s.btn_prev = clean.btn;
    // Free-running blink phase shared by all flashing indicators
    if (s.blink_cnt >= BLINK_CYC - 32'h1) begin
      next_s.blink_cnt = 32'h0;
      next_s.blink = ~s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 32'h1;
    end
    case (s.phase)
      PH_BOOT: begin
        next_s.led = fcms_onehot(s.boot_idx);
        next_s.relay = 4'h0;
        if (s.tmr >= BOOT_CYC - 32'h1) begin
          next_s.tmr = 32'h0;
          if (s.boot_idx == 2'h3) begin
            // Storage is read at the end of the sequence, well after reset release
            next_s.phase = PH_RUN;
            if (NV_RESTORE_VALID) begin
              next_s.sel = NV_RESTORE.sel;
              next_s.route = NV_RESTORE.sel;
              next_s.autoscan = NV_RESTORE.autoscan;
            end
            next_s.dwell = 32'h0;
            next_s.hold_done = clean.btn;
          end else begin
            next_s.boot_idx = s.boot_idx + 2'h1;
          end
        end else begin
          next_s.tmr = s.tmr + 32'h1;
        end
      end
      PH_RUN: begin
        if (clean.pfail) begin
          next_s.phase = PH_HALT;
          next_s.nv_write = 1'b1;
          next_s.nv_data = '{autoscan: s.autoscan, sel: s.sel};
        end
        // Hold timing; a hold that fires is not also a short press
        if (press) begin
          next_s.hold_cnt = 32'h0;
          next_s.hold_done = 1'b0;
        end else if (clean.btn && !s.hold_done) begin
          if (s.hold_cnt >= HOLD_CYC - 32'h1) begin
            next_s.hold_done = 1'b1;
            next_s.autoscan = 1'b1;
            next_s.dwell = 32'h0;
          end else begin
            next_s.hold_cnt = s.hold_cnt + 32'h1;
          end
        end
        if (release_evt && !s.hold_done) begin
          next_s.sel = fcms_next_ch(s.sel);
          next_s.autoscan = 1'b0;
          next_s.settle_pend = 1'b1;
          next_s.tmr = 32'h0;
        end else if (s.settle_pend) begin
          if (s.tmr >= SETTLE_CYC - 32'h1) begin
            next_s.settle_pend = 1'b0;
            next_s.route = s.sel;
          end else begin
            next_s.tmr = s.tmr + 32'h1;
          end
        end else if (s.autoscan) begin
          if (s.dwell >= DWELL_CYC - 32'h1) begin
            next_s.dwell = 32'h0;
            next_s.sel = fcms_next_ch(s.sel);
            next_s.route = fcms_next_ch(s.sel);
          end else begin
            next_s.dwell = s.dwell + 32'h1;
          end
        end
        // Only the selected circuit lights steady; a low supply flashes instead
        for (int i = 0; i < 4; i++) begin
          next_s.led[i] = clean.uv[i] ? s.blink : (s.sel == i[1:0]);
        end
        next_s.relay = fcms_onehot(s.route);
      end
      PH_HALT: begin
        // Holds the saved state until the supply collapses and resets the block
        next_s.relay = fcms_onehot(s.route);
      end
      default: begin
        next_s.phase = PH_BOOT;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign LED = s.led;
  assign RELAY = s.relay;
  assign NV_WRITE = s.nv_write;
  assign NV_WDATA = s.nv_data;
  assign AUTOSCAN = s.autoscan;

endmodule : fcms_top

// *** test/fcms_properties.sv ***
`timescale 1ns/1ps
module fcms_properties (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic BUTTON,
  input wire logic [3:0] UNDER_VOLT,
  input wire logic [3:0] LED,
  input wire logic [3:0] RELAY,
  input wire logic NV_WRITE,
  input wire fcms_pkg::fcms_nv_t NV_WDATA,
  input wire logic AUTOSCAN
);
  import fcms_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic btn_q;
  logic [7:0] idle;
  // Cycles since the raw button last moved, saturating
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      btn_q <= 1'b0;
      idle <= 8'h0;
    end else begin
      btn_q <= BUTTON;
      idle <= (BUTTON != btn_q) ? 8'h0 : idle + {7'h0, idle != 8'hff};
    end
  end
  // Long enough for the under-voltage synchroniser to settle
  sequence s_calm;
    (UNDER_VOLT == 4'h0) [*6];
  endsequence
  a_relay_onehot: assert property (RELAY == 4'h0 || $onehot(RELAY))
    else $error("more than one relay energised");
  a_led_single: assert property (s_calm |-> $countones(LED) == 1)
    else $error("not exactly one indicator lit");
  a_nv_pulse: assert property (NV_WRITE |=> !NV_WRITE [*8])
    else $error("storage write repeated");
  a_nv_data: assert property (NV_WRITE |-> NV_WDATA.autoscan == AUTOSCAN)
    else $error("stored scan flag wrong");
  a_halt_freeze: assert property (NV_WRITE |=> $stable(RELAY) [*8])
    else $error("relays moved after power loss");
  a_hold_scan: assert property ($rose(AUTOSCAN) && $past(RELAY) != 4'h0 |-> BUTTON)
    else $error("auto scan started without a held button");
  a_short_exit: assert property ($fell(AUTOSCAN) |-> !BUTTON)
    else $error("auto scan ended without a release");
  a_relay_settle: assert property ($changed(RELAY) && !AUTOSCAN && $past(RELAY) != 4'h0
    |-> idle >= 8'h1e)
    else $error("relay switched before settling");
endmodule : fcms_properties

// *** test/fcms_panel.sv ***
`timescale 1ns/1ps
module fcms_panel (
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] high,
  output logic button,
  output logic busy
);
  logic [8:0] cnt = 9'h0;
  // Every press is followed by 12 released cycles so the debouncer sees it
  always @(posedge clock) begin
    if (go) cnt <= {1'b0, high} + 9'hc;
    else if (cnt != 9'h0) cnt <= cnt - 9'h1;
  end
  assign button = cnt > 9'hc;
  assign busy = go || cnt != 9'h0;
endmodule : fcms_panel

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module testbench;
  import fcms_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic go = 1'b0;
  logic [7:0] high = 8'h0;
  logic [3:0] UNDER_VOLT = 4'h0;
  logic POWER_FAIL = 1'b0;
  fcms_nv_t NV_RESTORE = 3'h2;
  logic NV_RESTORE_VALID = 1'b1;
  logic BUTTON, busy, NV_WRITE, AUTOSCAN;
  logic [3:0] LED, RELAY;
  fcms_nv_t NV_WDATA;
  int n_errors = 0;
  int checks = 0;
  int t;
  always #2 CLOCK = ~CLOCK;
  fcms_top #(.HOLD_CYC(40), .DWELL_CYC(60), .SETTLE_CYC(30), .BLINK_CYC(8), .BOOT_CYC(5),
    .DEB_CYC(3)) u_dut (.CLOCK, .RST_N, .BUTTON, .UNDER_VOLT, .POWER_FAIL, .NV_RESTORE,
    .NV_RESTORE_VALID, .LED, .RELAY, .NV_WRITE, .NV_WDATA, .AUTOSCAN);
  fcms_panel u_panel (.clock(CLOCK), .go, .high, .button(BUTTON), .busy);
  task end_sim;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task tmo(input int lim);
    if (t >= lim) begin
      n_errors++;
      end_sim();
    end
  endtask : tmo
  task wait_chg(input bit rel, input logic [3:0] e);
    logic [3:0] old;
    old = rel ? RELAY : LED;
    t = 0;
    do begin
      @(posedge CLOCK);
      #1;
      t++;
    end while ((rel ? RELAY : LED) === old && t < 300);
    tmo(300);
    `CHK("out", e, rel ? RELAY : LED)
  endtask : wait_chg
  task press(input logic [7:0] n);
    @(posedge CLOCK);
    high <= n;
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    for (t = 0; t < 200 && busy; t++) @(posedge CLOCK);
    tmo(200);
  endtask : press
  task t_boot;
    wait_chg(0, 4'h1);
    wait_chg(0, 4'h2);
    wait_chg(0, 4'h4);
    wait_chg(0, 4'h8);
    wait_chg(0, 4'h4);
    // Relay and indicator leave boot on the same edge
    `CHK("relay", 4'h4, RELAY)
    $display("t_boot done");
  endtask : t_boot
  task t_press;
    press(8'ha);
    wait_chg(1, 4'h8);
    press(8'ha);
    press(8'ha);
    wait_chg(1, 4'h2);
    `CHK("led", 4'h2, LED)
    $display("t_press done");
  endtask : t_press
  task t_scan;
    press(8'h3c);
    `CHK("scan", 1'b1, AUTOSCAN)
    wait_chg(1, 4'h4);
    wait_chg(1, 4'h8);
    `CHK("dwell", 60, t)
    wait_chg(1, 4'h1);
    press(8'ha);
    `CHK("scan", 1'b0, AUTOSCAN)
    `CHK("led", 4'h2, LED)
    $display("t_scan done");
  endtask : t_scan
  task t_uv;
    logic p;
    int n;
    @(posedge CLOCK);
    UNDER_VOLT <= 4'h8;
    repeat (8) @(posedge CLOCK);
    #1;
    p = LED[3];
    n = 0;
    repeat (48) begin
      @(posedge CLOCK);
      #1;
      n += int'(LED[3] !== p);
      p = LED[3];
    end
    `CHK("blink", 1'b1, n >= 5 && n <= 6)
    `CHK("steady", 1'b1, LED[1])
    UNDER_VOLT <= 4'h0;
    $display("t_uv done");
  endtask : t_uv
  task t_pfail;
    @(posedge CLOCK);
    POWER_FAIL <= 1'b1;
    for (t = 0; t < 50 && NV_WRITE !== 1'b1; t++) begin
      @(posedge CLOCK);
      #1;
    end
    tmo(50);
    `CHK("nv", 3'h1, NV_WDATA)
    @(posedge CLOCK);
    RST_N <= 1'b0;
    POWER_FAIL <= 1'b0;
    NV_RESTORE <= 3'h7;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    wait_chg(1, 4'h8);
    `CHK("scan", 1'b1, AUTOSCAN)
    // Empty storage: boot falls back to the first circuit, manual mode
    @(posedge CLOCK);
    RST_N <= 1'b0;
    NV_RESTORE_VALID <= 1'b0;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    wait_chg(1, 4'h1);
    `CHK("scan", 1'b0, AUTOSCAN)
    $display("t_pfail done");
  endtask : t_pfail
  initial begin
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_boot();
    t_press();
    t_scan();
    t_uv();
    t_pfail();
    end_sim();
  end
endmodule : testbench
bind fcms_top fcms_properties u_props (.CLOCK, .RST_N, .BUTTON, .UNDER_VOLT, .LED, .RELAY,
  .NV_WRITE, .NV_WDATA, .AUTOSCAN);
